/* design/pie_intr_status.sv */
// Top of the PHY interrupt control/status register and its interrupt.
//
// What this block does
// RULE1 - Eight status flags, bits 0..7, each latch high on their PHY event.
// RULE2 - A management read of the register clears the flags; writes never do.
// RULE3 - Bits 8..15 are enables; each lets flag eight lower raise the interrupt.
// RULE4 - Register answers at management address 0x11 and resets to 0x0000.
// RULE5 - Flags may be polled by reading, with all interrupts disabled.
// RULE6 - Flags 7..0: jabber, rx error, page, detect, ack, link, fault, aneg.
// RULE7 - Enables mirror flags eight higher and are read/write.
// RULE8 - Event during clearing read keeps flag set; interrupt is OR of enabled.
`timescale 1ns/10ps
module pie_intr_status
    import pie_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_rd,
    input wire logic mgmt_wr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire logic jabber_event,
    input wire logic receive_error_event,
    input wire logic page_received_event,
    input wire logic parallel_detect_fault_event,
    input wire logic link_partner_ack_event,
    input wire logic link_status_change_event,
    input wire logic remote_fault_event,
    input wire logic autoneg_done_event,
    output logic phy_interrupt
);
    // ------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] enables;
        logic [15:0] rdata;
        logic rvalid;
        logic irq;
    } pie_state_t;

    pie_state_t state;
    pie_state_t next_state;
    logic [7:0] events;
    logic rd_hit;
    logic wr_hit;
    logic [7:0] next_flags;
    pie_flag_if fl();

    // Gather events into their flag positions.
    always_comb begin
        events = PIE_BYTE_ZERO;
        events[PIE_BIT_JABBER] = jabber_event; // [RULE6]
        events[PIE_BIT_RECEIVE_ERROR] = receive_error_event;
        events[PIE_BIT_PAGE_RECEIVED] = page_received_event;
        events[PIE_BIT_PARALLEL_DETECT_FAULT] = parallel_detect_fault_event;
        events[PIE_BIT_LINK_PARTNER_ACK] = link_partner_ack_event;
        events[PIE_BIT_LINK_STATUS_CHANGE] = link_status_change_event;
        events[PIE_BIT_REMOTE_FAULT] = remote_fault_event;
        events[PIE_BIT_AUTONEG_DONE] = autoneg_done_event;
    end

    // Address decode; other addresses belong to other PHY registers.
    assign rd_hit = mgmt_rd && (mgmt_addr == PIE_REG_ADDR); // [RULE4]
    assign wr_hit = mgmt_wr && (mgmt_addr == PIE_REG_ADDR); // [RULE4]

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    // A read clears every flag; the bank lets a same-cycle event win.
    assign fl.event_set = events; // [RULE1]
    assign fl.flag_clear = rd_hit ? 8'hFF : PIE_BYTE_ZERO; // [RULE2]

    pie_flag_bank #(
        .WIDTH(PIE_NUM_EVT)
    ) u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .fl(fl.bank)
    );

    // Mirror of the bank's next value, so the interrupt is a flop that
    // tracks the flags with no extra cycle of lag.
    assign next_flags = (fl.flags & ~fl.flag_clear) | events; // [RULE8]

    // ------------------------------------------------------------
    // Register access and interrupt
    // ------------------------------------------------------------
    // A read is answered one cycle after its strobe, and the answer
    // stands for that cycle only; rvalid pulses for any address so the
    // management controller never waits on a miss.
    // The read data shows the flags as they were before the clearing
    // edge, so an event in the read's own cycle is reported by the
    // next read instead of being lost. A read and a write in one cycle
    // both act: the read returns the old enables.
    // The interrupt is registered, which keeps the pin glitch free; it
    // moves on the same edge as the flags that drive it.
    always_comb begin
        next_state = state;
        next_state.rvalid = mgmt_rd;
        // Misses read as zero so a shared read mux can OR answers.
        next_state.rdata = PIE_DATA_ZERO;
        if (rd_hit) begin
            next_state.rdata = {state.enables, fl.flags}; // [RULE5] [RULE7]
        end
        // Writes touch only the enables; the flag byte is ignored.
        if (wr_hit) begin
            next_state.enables = mgmt_wdata[PIE_EN_MSB:PIE_EN_LSB]; // [RULE7]
        end
        next_state.irq = |(next_flags & next_state.enables); // [RULE3]
    end

    // Register the state; synchronous reset loads the documented zeros.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '0; // [RULE4]
        end else begin
            state <= next_state;
        end
    end

    // Every output comes straight from the state flops.
    assign mgmt_rdata = state.rdata;
    assign mgmt_rvalid = state.rvalid;
    assign phy_interrupt = state.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence rd_quiet_s;
        rd_hit && (events == PIE_BYTE_ZERO);
    endsequence

    sequence rd_clash_s;
        rd_hit && (events != PIE_BYTE_ZERO);
    endsequence

    flag_latch_a: assert property ((events != PIE_BYTE_ZERO) |=> // [RULE1]
        ((fl.flags & $past(events)) == $past(events)))
        else $error("Event did not latch its flag.");

    read_clear_a: assert property (rd_quiet_s |=> // [RULE2]
        (fl.flags == PIE_BYTE_ZERO))
        else $error("Read did not clear the flags.");

    write_keeps_a: assert property ( // [RULE2]
        (wr_hit && !mgmt_rd && events == PIE_BYTE_ZERO) |=>
        (fl.flags == $past(fl.flags)))
        else $error("Write changed the flags.");

    irq_gating_a: assert property ( // [RULE3]
        phy_interrupt == |(fl.flags & state.enables))
        else $error("Interrupt does not match enabled flags.");

    reset_zero_a: assert property (@(posedge clk) disable iff (1'b0) // [RULE4]
        !rst_n |=> (fl.flags == PIE_BYTE_ZERO && state.enables ==
        PIE_BYTE_ZERO && !phy_interrupt && mgmt_rdata == PIE_REG_RESET))
        else $error("Reset did not zero the register.");

    miss_read_a: assert property ( // [RULE4]
        (mgmt_rd && mgmt_addr != PIE_REG_ADDR) |=>
        (mgmt_rvalid && mgmt_rdata == PIE_DATA_ZERO))
        else $error("Unmatched address returned data.");

    poll_read_a: assert property (rd_hit |=> // [RULE5]
        (mgmt_rvalid && mgmt_rdata ==
        {$past(state.enables), $past(fl.flags)}))
        else $error("Poll returned wrong contents.");

    enable_write_a: assert property (wr_hit |=> // [RULE7]
        (state.enables == $past(mgmt_wdata[PIE_EN_MSB:PIE_EN_LSB])))
        else $error("Enable write not stored.");

    clash_wins_a: assert property (rd_clash_s |=> // [RULE8]
        (fl.flags == $past(events)))
        else $error("Event lost in clearing read.");

    // Flags hold when neither an event nor a hit read touches them.
    flag_hold_a: assert property ( // [RULE1]
        (!rd_hit && events == PIE_BYTE_ZERO) |=>
        (fl.flags == $past(fl.flags)))
        else $error("Flags changed with no event or read.");

    // A quiet read drops the interrupt along with the flags.
    read_irq_a: assert property (rd_quiet_s |=> !phy_interrupt) // [RULE2]
        else $error("Interrupt survived a clearing read.");

    sequence enabled_event_s;
        (events & next_state.enables) != PIE_BYTE_ZERO;
    endsequence

    // An enabled event reaches the pin on the edge that latches it.
    irq_raise_a: assert property (enabled_event_s |=> // [RULE3]
        phy_interrupt)
        else $error("Enabled event did not raise the interrupt.");

    // Without a read strobe the read port stays idle and zero.
    idle_port_a: assert property (!mgmt_rd |=> // [RULE4]
        (!mgmt_rvalid && mgmt_rdata == PIE_DATA_ZERO))
        else $error("Read port active without a read.");

    // With all enables clear the flags can be polled but never interrupt.
    poll_silent_a: assert property ( // [RULE5]
        (state.enables == PIE_BYTE_ZERO) |-> !phy_interrupt)
        else $error("Interrupt raised with all enables clear.");

    // The outermost events land in the outermost flag slots.
    jabber_slot_a: assert property (jabber_event |=> // [RULE6]
        fl.flags[PIE_BIT_JABBER])
        else $error("Jabber event missed its flag.");

    autoneg_slot_a: assert property (autoneg_done_event |=> // [RULE6]
        fl.flags[PIE_BIT_AUTONEG_DONE])
        else $error("Autoneg event missed its flag.");

    // Enables move only through a write that hits this register.
    enable_hold_a: assert property (!wr_hit |=> // [RULE7]
        (state.enables == $past(state.enables)))
        else $error("Enables changed without a write.");
endmodule // pie_intr_status

/* design/pie_pkg.sv */
// Constants and field layout of the PHY interrupt control/status block.
package pie_pkg;
    localparam int PIE_NUM_EVT = 8;
    localparam int PIE_ADDR_W = 5;
    localparam int PIE_DATA_W = 16;
    // Management register address of the control/status register.
    localparam logic [4:0] PIE_REG_ADDR = 5'h11;
    localparam logic [15:0] PIE_REG_RESET = 16'h0000;
    localparam logic [7:0] PIE_BYTE_ZERO = 8'h00;
    localparam logic [15:0] PIE_DATA_ZERO = 16'h0000;
    // Status flag positions in the low byte; enables sit eight higher.
    localparam int PIE_BIT_AUTONEG_DONE = 0;
    localparam int PIE_BIT_REMOTE_FAULT = 1;
    localparam int PIE_BIT_LINK_STATUS_CHANGE = 2;
    localparam int PIE_BIT_LINK_PARTNER_ACK = 3;
    localparam int PIE_BIT_PARALLEL_DETECT_FAULT = 4;
    localparam int PIE_BIT_RECEIVE_ERROR = 5 + 1;
    localparam int PIE_BIT_PAGE_RECEIVED = 5;
    localparam int PIE_BIT_JABBER = 7;
    localparam int PIE_EN_LSB = 8;
    localparam int PIE_EN_MSB = 15;
    localparam int PIE_FLAG_MSB = 7;
endpackage

/* design/pie_flag_if.sv */
// Carrier between the register front end and the sticky flag bank.
`timescale 1ns/10ps
interface pie_flag_if;
    logic [7:0] event_set;
    logic [7:0] flag_clear;
    logic [7:0] flags;
    modport bank (input event_set, input flag_clear, output flags);
    modport ctrl (output event_set, output flag_clear, input flags);
endinterface

/* design/pie_flag_bank.sv */
// Bank of sticky event flags where a set always beats a clear.
`timescale 1ns/10ps
module pie_flag_bank
    import pie_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    pie_flag_if.bank fl
);
    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } pie_bank_state_t;

    pie_bank_state_t state;
    pie_bank_state_t next_state;

    // Clear first, then OR in events, so a clashing event survives.
    always_comb begin
        next_state = state;
        next_state.flags = (state.flags & ~fl.flag_clear) | fl.event_set;
    end

    // Register the state; synchronous reset to all zeros.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // The flags leave the bank straight from its flops.
    assign fl.flags = state.flags;

    // An event raises its flag on the next edge, clear or no clear.
    bank_set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 ((fl.flags & $past(fl.event_set)) == $past(fl.event_set)))
        else $error("Event lost in flag bank."); // [RULE8]
endmodule // pie_flag_bank

/* test/pie_mac_model.sv */
// Model of the MAC raw interrupt status bit fed by the PHY.
`timescale 1ns/10ps
module pie_mac_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic phy_interrupt,
    input wire logic status_clear,
    output logic mac_raw_interrupt_status
);
    // Sticky, so that a short interrupt is not missed by software.
    always_ff @(posedge clk) begin
        if (!rst_n || status_clear)
            mac_raw_interrupt_status <= 1'h0;
        else if (phy_interrupt)
            mac_raw_interrupt_status <= 1'h1;
    end
endmodule // pie_mac_model

/* test/tb_top.sv */
// Self-checking bench of the PHY interrupt control/status register.
`timescale 1ns/10ps
module tb_top;
    import pie_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [4:0] addr = 5'h00;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic clr = 1'h0;
    logic [15:0] wdata = 16'h0000;
    logic [7:0] ev = 8'h00;
    logic [15:0] rdata;
    logic rvalid;
    logic irq;
    logic raw;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int i;
    always #5 clk = ~clk;
    // Event bit i of ev drives the event whose flag sits at bit i.
    pie_intr_status pie_intr_status_i (.clk(clk), .rst_n(rst_n),
        .mgmt_addr(addr), .mgmt_rd(rd), .mgmt_wr(wr), .mgmt_wdata(wdata),
        .mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .jabber_event(ev[7]),
        .receive_error_event(ev[6]), .page_received_event(ev[5]),
        .parallel_detect_fault_event(ev[4]),
        .link_partner_ack_event(ev[3]), .link_status_change_event(ev[2]),
        .remote_fault_event(ev[1]), .autoneg_done_event(ev[0]),
        .phy_interrupt(irq));
    pie_mac_model pie_mac_model_i (.clk(clk), .rst_n(rst_n),
        .phy_interrupt(irq), .status_clear(clr),
        .mac_raw_interrupt_status(raw));
    task automatic conclude;
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Each task starts just after an edge and leaves an idle cycle behind.
    task automatic write(input logic [4:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr = 1'h1;
        @(posedge clk);
        #1 wr = 1'h0;
        @(posedge clk);
        #1;
    endtask
    task automatic read(input logic [4:0] a, input logic [7:0] e,
                        input logic [15:0] exp);
        addr = a;
        ev = e;
        rd = 1'h1;
        @(posedge clk);
        #1 rd = 1'h0;
        ev = 8'h00;
        check("rdata", rdata, exp);
        check("rvalid", {15'h0000, rvalid}, 16'h0001);
        @(posedge clk);
        #1 check("rvalid end", {15'h0000, rvalid}, 16'h0000);
    endtask
    task automatic pulse(input logic [7:0] e);
        ev = e;
        @(posedge clk);
        #1 ev = 8'h00;
        @(posedge clk);
        #1;
    endtask
    // Watchdog: the whole run needs about 150 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1'h1;
        read(PIE_REG_ADDR, 8'h00, PIE_REG_RESET);
        for (i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            check("irq poll", {15'h0000, irq}, 16'h0000);
            read(PIE_REG_ADDR, 8'h00, 16'h0001 << i);
            read(PIE_REG_ADDR, 8'h00, 16'h0000);
        end
        check("mac raw poll", {15'h0000, raw}, 16'h0000);
        // A write must neither set nor clear the flags.
        pulse(8'hA5);
        write(PIE_REG_ADDR, 16'hFF5A);
        read(PIE_REG_ADDR, 8'h00, 16'hFFA5);
        check("irq read", {15'h0000, irq}, 16'h0000);
        write(5'h10, 16'h0000);
        read(5'h10, 8'h00, 16'h0000);
        read(PIE_REG_ADDR, 8'h00, 16'hFF00);
        for (i = 0; i < 8; i++) begin
            write(PIE_REG_ADDR, 16'h0100 << i);
            pulse(~(8'h01 << i));
            check("irq masked", {15'h0000, irq}, 16'h0000);
            pulse(8'h01 << i);
            check("irq", {15'h0000, irq}, 16'h0001);
            read(PIE_REG_ADDR, 8'h00, (16'h0100 << i) | 16'h00FF);
            check("irq clr", {15'h0000, irq}, 16'h0000);
        end
        check("mac raw", {15'h0000, raw}, 16'h0001);
        clr = 1'h1;
        // An event in the clearing read's cycle must survive it.
        read(PIE_REG_ADDR, 8'h04, 16'h8000);
        check("mac raw clr", {15'h0000, raw}, 16'h0000);
        read(PIE_REG_ADDR, 8'h00, 16'h8004);
        // Read and write in one cycle: the read returns the old enables.
        wdata = 16'h0100;
        wr = 1'h1;
        read(PIE_REG_ADDR, 8'h00, 16'h8000);
        wr = 1'h0;
        read(PIE_REG_ADDR, 8'h00, 16'h0100);
        conclude();
    end
endmodule // tb_top
